// ===== rtl/cc_array_pkg.sv
// Purpose: shared constants and types of the capture/compare module array
// Assumes: 8-bit special function register access, one shared 16-bit counter
// Notes:   register addresses are local to the block
package cc_array_pkg;

    // ========================================
    // register addresses
    localparam logic [7:0] ADDR_EVENT     = 8'h00;
    localparam logic [7:0] ADDR_PWM_CFG   = 8'h01;
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h02;
    localparam logic [7:0] ADDR_MODE_BASE = 8'h04;
    localparam logic [7:0] ADDR_CMP_BASE  = 8'h08;

    // ========================================
    // reset values and field layout
    localparam logic [7:0] MODE_RESET     = 8'h00;
    localparam logic [7:0] PWM_CFG_RESET  = 8'h00;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    localparam logic [15:0] WORD_ZERO     = 16'h0000;
    localparam logic [4:0] PWM_BASE_BITS  = 5'h08;
    localparam logic [1:0] CYCLE_LENGTH_SEL_8BIT     = 2'h0;

    // ========================================
    // carriers
    typedef struct packed {
        logic wide_pwm_select;
        logic comparator_enable;
        logic capture_rise_sel;
        logic capture_fall_sel;
        logic match_flag_enable;
        logic toggle_enable;
        logic pwm_enable;
        logic module_irq_enable;
    } module_mode_type;

    typedef struct packed {
        logic       reload_access_sel;
        logic       short_overflow_flag;
        logic       overflow_irq_enable;
        logic [2:0] reserved;
        logic [1:0] cycle_length_sel;
    } pwm_cfg_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sfr_req_type;

endpackage

// ===== rtl/counter_array_capture_compare.sv
// Purpose: capture/compare modules sharing one 16-bit counter
// Assumes: counter value and its step pulse come from logic on i_clk
// Notes:   module pins are sampled through three flip-flops
`timescale 1ns/1ps

// Function
// [RULE1] capture copies the 16-bit counter on the selected pin edge
// [RULE2] outside signal holds each level two clocks before it counts
// [RULE3] pin level stays readable so software sees which edge captured
// [RULE4] event flag set by hardware, stays until software writes zero
// [RULE5] interrupt request is event flag gated by module irq enable bit 0
// [RULE6] software timer sets the flag on full 16-bit counter match
// [RULE7] writing compare low clears comparator enable, writing high sets it
// [RULE8] software writes compare low byte before the high byte
// [RULE9] high-speed output toggles pin and sets flag on 16-bit match
// [RULE10] comparator off holds toggle and frequency pin at its level
// [RULE11] frequency mode toggles on low byte match and adds high byte
// [RULE12] half period equals high byte counts, zero meaning 256
// [RULE13] frequency mode selection; match flag on full 16-bit equality
// [RULE14] all 8 to 11-bit PWM modules share one cycle length
// [RULE15] 8-bit PWM sets pin on low byte match, clears on overflow
// [RULE16] 8-bit PWM reloads compare low byte from high byte at rollover
// [RULE17] 8-bit PWM selected by comparator and pwm enable, length 00; code selects on pwm enable with toggle and wide select off, not comparator
// [RULE18] PWM match sets event flag; short overflow flag marks falling edge
// [RULE19] PWM with comparator off drives a constant low output
// [RULE20] cycle length select chooses 8 to 11 bits; wide select is 16-bit
// [RULE21] reload access select routes compare addresses to reload register
// [RULE22] config bit 5 enables interrupt on the selected counter bit overflow
// [RULE23] three modules, each with 16-bit register and pin, share counter
// [RULE24] mode and PWM configuration bits reset to zero
module counter_array_capture_compare
    import cc_array_pkg::*;
#(
    parameter int MODULES = 3
) (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_arst_n,
    // register access
    input  wire sfr_req_type          i_sfr,
    output logic [7:0]                o_sfr_rdata,
    // shared counter
    input  wire logic [15:0]          i_count,
    input  wire logic                 i_count_step,
    // module pins
    input  wire logic [MODULES-1:0]   i_pin,
    output logic [MODULES-1:0]        o_pin,
    output logic [MODULES-1:0]        o_pin_oe_n,
    // interrupt requests
    output logic [MODULES-1:0]        o_module_irq,
    output logic                      o_overflow_irq
);

    // ========================================
    // reset release
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    // ========================================
    // shared state
    module_mode_type              mode_reg [MODULES];
    logic [15:0]                  ccr      [MODULES];
    logic [15:0]                  reload   [MODULES];
    logic [MODULES-1:0]           event_flag;
    logic [MODULES-1:0]           pin_level;
    pwm_cfg_type                  pwm_config_reg;
    logic [4:0]                   pwm_bits;
    logic [15:0]                  pwm_mask;
    logic                         ovf_n;
    logic                         ovf_16;
    logic                         wr_pwm_cfg;
    logic                         wr_event;

    // ========================================
    // register write strobes
    assign wr_pwm_cfg = i_sfr.wr && (i_sfr.addr == ADDR_PWM_CFG);
    assign wr_event   = i_sfr.wr && (i_sfr.addr == ADDR_EVENT);

    // ========================================
    // cycle length and overflow decode
    // [RULE14] one shared length
    // [RULE20] length from select
    always_comb begin
        pwm_bits = PWM_BASE_BITS + {3'b000, pwm_config_reg.cycle_length_sel};
        pwm_mask = 16'((17'h00001 << pwm_bits) - 17'h00001);
    end

    assign ovf_n  = i_count_step && ((i_count & pwm_mask) == WORD_ZERO);
    assign ovf_16 = i_count_step && (i_count == WORD_ZERO);

    // ========================================
    // pwm configuration and short overflow flag
    // [RULE24] cleared at reset
    // [RULE18] overflow flag, set wins
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_config_reg <= PWM_CFG_RESET;
        end else begin
            if (wr_pwm_cfg) begin
                pwm_config_reg.reload_access_sel   <= i_sfr.wdata[7];
                pwm_config_reg.overflow_irq_enable <= i_sfr.wdata[5];
                pwm_config_reg.cycle_length_sel    <= i_sfr.wdata[1:0];
            end
            if (ovf_n) begin
                pwm_config_reg.short_overflow_flag <= 1'b1;
            end else if (wr_pwm_cfg && !i_sfr.wdata[6]) begin
                pwm_config_reg.short_overflow_flag <= 1'b0;
            end
        end
    end

    // [RULE22] overflow interrupt
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_overflow_irq <= 1'b0;
        end else begin
            o_overflow_irq <= pwm_config_reg.short_overflow_flag
                              && pwm_config_reg.overflow_irq_enable;
        end
    end

    // ========================================
    // capture/compare modules
    // [RULE23] one slice per module
    genvar g;
    generate
        for (g = 0; g < MODULES; g++) begin : g_mod
            logic [2:0]      pin_sync;
            logic            wr_mode;
            logic            wr_lo;
            logic            wr_hi;
            logic            rise;
            logic            fall;
            logic            capture_evt;
            logic            match_16;
            logic            match_lo;
            logic            match_n;
            logic            freq_mode;
            logic            pwm_n_mode;
            logic            pwm_16_mode;
            logic            hit;
            module_mode_type m;

            // ========================================
            // mode view and write strobes
            assign m       = mode_reg[g];
            assign wr_mode = i_sfr.wr && (i_sfr.addr == 8'(int'(ADDR_MODE_BASE) + g));
            assign wr_lo   = i_sfr.wr && (i_sfr.addr == 8'(int'(ADDR_CMP_BASE) + 2 * g));
            assign wr_hi   = i_sfr.wr && (i_sfr.addr == 8'(int'(ADDR_CMP_BASE) + 2 * g + 1));

            // ========================================
            // pin sampling and edge detect
            // [RULE2] three-stage pin sampling
            always_ff @(posedge i_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_sync     <= 3'b000;
                    pin_level[g] <= 1'b0;
                end else begin
                    pin_sync <= {pin_sync[1:0], i_pin[g]};
                    if (pin_sync[2] == pin_sync[1]) begin
                        pin_level[g] <= pin_sync[2];
                    end
                end
            end

            assign rise = (pin_sync[2] == pin_sync[1]) && pin_sync[2] && !pin_level[g];
            assign fall = (pin_sync[2] == pin_sync[1]) && !pin_sync[2] && pin_level[g];
            // [RULE1] edge selection
            assign capture_evt = (rise && m.capture_rise_sel) || (fall && m.capture_fall_sel);

            // ========================================
            // compare decode
            assign match_16 = i_count_step && (i_count == ccr[g]);
            assign match_lo = i_count_step && (i_count[7:0] == ccr[g][7:0]);
            assign match_n  = i_count_step && ((i_count & pwm_mask) == (ccr[g] & pwm_mask));

            // [RULE13] frequency selection
            assign freq_mode   = m.comparator_enable && m.toggle_enable && m.pwm_enable;
            // [RULE17] narrow PWM selection
            assign pwm_n_mode  = m.pwm_enable && !m.toggle_enable && !m.wide_pwm_select;
            assign pwm_16_mode = m.pwm_enable && !m.toggle_enable && m.wide_pwm_select;
            assign hit         = pwm_n_mode ? match_n : match_16;

            // ========================================
            // mode and compare registers
            // [RULE7] comparator enable by writes
            // [RULE24] mode cleared at reset
            always_ff @(posedge i_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mode_reg[g] <= MODE_RESET;
                end else if (wr_mode) begin
                    mode_reg[g] <= i_sfr.wdata;
                end else if (wr_lo) begin
                    mode_reg[g].comparator_enable <= 1'b0;
                end else if (wr_hi) begin
                    mode_reg[g].comparator_enable <= 1'b1;
                end
            end

            // [RULE21] reload register access
            always_ff @(posedge i_clk or negedge rst_n) begin
                if (!rst_n) begin
                    reload[g] <= WORD_ZERO;
                end else if (pwm_config_reg.reload_access_sel) begin
                    if (wr_lo) begin
                        reload[g][7:0] <= i_sfr.wdata;
                    end
                    if (wr_hi) begin
                        reload[g][15:8] <= i_sfr.wdata;
                    end
                end
            end

            always_ff @(posedge i_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ccr[g] <= WORD_ZERO;
                end else if (!pwm_config_reg.reload_access_sel && (wr_lo || wr_hi)) begin
                    if (wr_lo) begin
                        ccr[g][7:0] <= i_sfr.wdata;
                    end
                    if (wr_hi) begin
                        ccr[g][15:8] <= i_sfr.wdata;
                    end
                // [RULE1] counter copy
                end else if (capture_evt) begin
                    ccr[g] <= i_count;
                // [RULE11] add high byte
                // [RULE12] zero high byte wraps
                end else if (freq_mode && match_lo) begin
                    ccr[g][7:0] <= ccr[g][7:0] + ccr[g][15:8];
                end else if (pwm_n_mode && ovf_n) begin
                    // [RULE16] 8-bit rollover reload
                    if (pwm_config_reg.cycle_length_sel == CYCLE_LENGTH_SEL_8BIT) begin
                        ccr[g][7:0] <= ccr[g][15:8];
                    end else begin
                        ccr[g] <= (ccr[g] & ~pwm_mask) | (reload[g] & pwm_mask);
                    end
                end
            end

            // ========================================
            // pin drive
            always_ff @(posedge i_clk or negedge rst_n) begin
                if (!rst_n) begin
                    o_pin[g]      <= 1'b0;
                    o_pin_oe_n[g] <= 1'b1;
                end else begin
                    o_pin_oe_n[g] <= !(m.toggle_enable || m.pwm_enable);
                    if (pwm_n_mode || pwm_16_mode) begin
                        // [RULE19] comparator off forces low
                        if (!m.comparator_enable) begin
                            o_pin[g] <= 1'b0;
                        // [RULE15] set on match
                        end else if (hit) begin
                            o_pin[g] <= 1'b1;
                        end else if (pwm_16_mode ? ovf_16 : ovf_n) begin
                            o_pin[g] <= 1'b0;
                        end
                    // [RULE10] hold when comparator off
                    end else if (m.toggle_enable && m.comparator_enable) begin
                        // [RULE9] toggle on match
                        // [RULE11] toggle on low byte
                        if (m.pwm_enable ? match_lo : match_16) begin
                            o_pin[g] <= !o_pin[g];
                        end
                    end
                end
            end

            // ========================================
            // event flag and request
            // [RULE4] sticky flag, set wins
            // [RULE6] timer match flag
            // [RULE18] PWM match flag
            always_ff @(posedge i_clk or negedge rst_n) begin
                if (!rst_n) begin
                    event_flag[g] <= 1'b0;
                end else if (capture_evt
                             || (m.match_flag_enable && m.comparator_enable && hit)) begin
                    event_flag[g] <= 1'b1;
                end else if (wr_event && !i_sfr.wdata[g]) begin
                    event_flag[g] <= 1'b0;
                end
            end

            // [RULE5] gated request
            always_ff @(posedge i_clk or negedge rst_n) begin
                if (!rst_n) begin
                    o_module_irq[g] <= 1'b0;
                end else begin
                    o_module_irq[g] <= event_flag[g] && m.module_irq_enable;
                end
            end
        end
    endgenerate

    // ========================================
    // register read
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_sfr_rdata <= BYTE_ZERO;
        end else if (i_sfr.rd) begin
            o_sfr_rdata <= BYTE_ZERO;
            if (i_sfr.addr == ADDR_EVENT) begin
                o_sfr_rdata <= 8'(event_flag);
            end else if (i_sfr.addr == ADDR_PWM_CFG) begin
                o_sfr_rdata <= {pwm_config_reg.reload_access_sel,
                                pwm_config_reg.short_overflow_flag,
                                pwm_config_reg.overflow_irq_enable,
                                3'b000,
                                pwm_config_reg.cycle_length_sel};
            // [RULE3] pin level readable
            end else if (i_sfr.addr == ADDR_PIN_LEVEL) begin
                o_sfr_rdata <= 8'(pin_level);
            end
            for (int k = 0; k < MODULES; k++) begin
                if (i_sfr.addr == 8'(int'(ADDR_MODE_BASE) + k)) begin
                    o_sfr_rdata <= mode_reg[k];
                end
                if (i_sfr.addr == 8'(int'(ADDR_CMP_BASE) + 2 * k)) begin
                    o_sfr_rdata <= pwm_config_reg.reload_access_sel ?
                                   reload[k][7:0] : ccr[k][7:0];
                end
                if (i_sfr.addr == 8'(int'(ADDR_CMP_BASE) + 2 * k + 1)) begin
                    o_sfr_rdata <= pwm_config_reg.reload_access_sel ?
                                   reload[k][15:8] : ccr[k][15:8];
                end
            end
        end
    end

endmodule

// ===== testbench/cc_array_properties.sv
// Purpose: port checker for the capture/compare array
// Assumes: register map of cc_array_pkg
// Notes:   bound to the top module
`timescale 1ns/1ps
module cc_array_properties
    import cc_array_pkg::*;
#(
    parameter int MODULES = 3
) (
    input wire logic               i_clk,
    input wire logic               i_arst_n,
    input wire sfr_req_type        i_sfr,
    input wire logic [7:0]         o_sfr_rdata,
    input wire logic               i_count_step,
    input wire logic [MODULES-1:0] i_pin,
    input wire logic [MODULES-1:0] o_pin,
    input wire logic [MODULES-1:0] o_module_irq,
    input wire logic               o_overflow_irq
);
    // ========================================
    // cycles since reset release
    logic [3:0] up;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            up <= 4'h0;
        end else if (up != 4'hf) begin
            up <= up + 4'h1;
        end
    end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    // ========================================
    // properties
    chk_unmapped_zero: assert property ((i_sfr.rd && (i_sfr.addr == 8'h07 || i_sfr.addr > 8'h0d))
        |=> o_sfr_rdata == 8'h00) else $error("unmapped read not zero");
    chk_reserved_zero: assert property ((i_sfr.rd && i_sfr.addr == ADDR_PWM_CFG)
        |=> o_sfr_rdata[4:2] == 3'h0) else $error("reserved bits not zero");
    chk_low_clears_en: assert property ((i_sfr.wr && i_sfr.addr == ADDR_CMP_BASE) ##1 !i_sfr.wr
        ##1 (i_sfr.rd && !i_sfr.wr && i_sfr.addr == ADDR_MODE_BASE) |=> !o_sfr_rdata[6])
        else $error("low byte write kept comparator");
    chk_high_sets_en: assert property ((i_sfr.wr && i_sfr.addr == ADDR_CMP_BASE + 8'h01)
        ##1 !i_sfr.wr ##1 (i_sfr.rd && !i_sfr.wr && i_sfr.addr == ADDR_MODE_BASE)
        |=> o_sfr_rdata[6]) else $error("high byte write left comparator off");
    chk_pin_level_read: assert property (($stable(i_pin) && up == 4'hf)[*5] ##0
        (i_sfr.rd && i_sfr.addr == ADDR_PIN_LEVEL) |=> o_sfr_rdata[MODULES-1:0] == $past(i_pin))
        else $error("pin level read wrong");
    chk_irq_has_flag: assert property ((i_sfr.rd && !i_sfr.wr && !$past(i_sfr.wr)
        && i_sfr.addr == ADDR_EVENT && o_module_irq[0]) |=> o_sfr_rdata[0])
        else $error("irq without event flag");
    chk_irq_fall_write: assert property ((|($past(o_module_irq) & ~o_module_irq))
        |-> $past(i_sfr.wr, 2)) else $error("irq dropped without write");
    chk_ovf_fall_write: assert property ($fell(o_overflow_irq) |-> $past(i_sfr.wr, 2))
        else $error("overflow irq dropped without write");
    chk_pin_has_cause: assert property ($changed(o_pin)
        |-> ($past(i_sfr.wr) || $past(i_sfr.wr, 2) || $past(i_count_step)))
        else $error("pin moved without step or write");
endmodule
bind counter_array_capture_compare cc_array_properties #(.MODULES(MODULES)) i_cc_array_properties (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata),
    .i_count_step(i_count_step), .i_pin(i_pin), .o_pin(o_pin), .o_module_irq(o_module_irq),
    .o_overflow_irq(o_overflow_irq)
);

// ===== testbench/cc_pin_model.sv
// Purpose: outside signal source for the module pins
// Assumes: bench sets the wanted level between clock edges
// Notes:   a new level waits until the old one has held long enough
`timescale 1ns/1ps
module cc_pin_model #(
    parameter int MIN_HOLD = 2
) (
    input  wire logic       i_clk,
    input  wire logic [2:0] i_want,
    output logic      [2:0] o_pin
);
    int held;
    initial begin
        o_pin = 3'h0;
        held  = 0;
    end
    always @(negedge i_clk) begin
        if (o_pin != i_want && held >= MIN_HOLD) begin
            o_pin <= i_want;
            held  <= 0;
        end else if (held < MIN_HOLD) begin
            held <= held + 1;
        end
    end
endmodule

// ===== testbench/counter_array_capture_compare_bench.sv
// Purpose: self-checking bench of the capture/compare array
// Assumes: bench drives register bus and counter on the falling edge
// Notes:   reads are noted in a queue and compared by a monitor
`timescale 1ns/1ps
module counter_array_capture_compare_bench
    import cc_array_pkg::*;
;
    logic        i_clk;
    logic        i_arst_n;
    sfr_req_type i_sfr;
    logic [7:0]  o_sfr_rdata;
    logic [15:0] i_count;
    logic        i_count_step;
    logic [2:0]  i_pin;
    logic [2:0]  want;
    logic [2:0]  o_pin;
    logic [2:0]  o_pin_oe_n;
    logic [2:0]  o_module_irq;
    logic        o_overflow_irq;
    logic        rd_q;
    logic [7:0]  exp_q[$];
    logic [15:0] cap;
    int          bad_count;
    int          tests_run;
    int          cycles;
    int          seed;
    counter_array_capture_compare #(.MODULES(3)) i_counter_array_capture_compare (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata),
        .i_count(i_count), .i_count_step(i_count_step), .i_pin(i_pin), .o_pin(o_pin),
        .o_pin_oe_n(o_pin_oe_n), .o_module_irq(o_module_irq), .o_overflow_irq(o_overflow_irq)
    );
    cc_pin_model #(.MIN_HOLD(2)) i_cc_pin_model (.i_clk(i_clk), .i_want(want), .o_pin(i_pin));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // ========================================
    // tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_sfr = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge i_clk);
        i_sfr.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk);
        i_sfr = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(negedge i_clk);
        i_sfr.rd = 1'b0;
    endtask
    task automatic step(input logic [15:0] v);
        @(negedge i_clk);
        i_count = v;
        i_count_step = 1'b1;
        @(negedge i_clk);
        i_count_step = 1'b0;
    endtask
    task automatic stop_test();
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ========================================
    // monitor and timeout
    always @(posedge i_clk) rd_q <= i_sfr.rd;
    always @(negedge i_clk) begin
        if (rd_q) begin
            check("rdata", {8'h00, o_sfr_rdata}, {8'h00, exp_q.pop_front()});
        end
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            stop_test();
        end
    end
    // ========================================
    // main sequence
    initial begin
        seed = 17;
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        i_arst_n = 1'b0;
        i_sfr = '0;
        i_count = 16'h0000;
        i_count_step = 1'b0;
        want = 3'h0;
        repeat (12) @(negedge i_clk);
        i_arst_n = 1'b1;
        repeat (3) @(negedge i_clk);
        for (int a = 0; a < 8; a++) begin
            rd(8'(a), 8'h00);
        end
        rd(8'h0e, 8'h00);
        wr(ADDR_MODE_BASE, 8'h49);
        wr(ADDR_CMP_BASE, 8'h34);
        rd(ADDR_MODE_BASE, 8'h09);
        wr(ADDR_CMP_BASE + 8'h01, 8'h12);
        rd(ADDR_MODE_BASE, 8'h49);
        step(16'h1233);
        rd(ADDR_EVENT, 8'h00);
        step(16'h1234);
        step(16'h1235);
        rd(ADDR_EVENT, 8'h01);
        check("irq", {13'h0, o_module_irq}, 16'h0001);
        wr(ADDR_MODE_BASE, 8'h48);
        @(negedge i_clk);
        check("irq", {13'h0, o_module_irq}, 16'h0000);
        wr(ADDR_EVENT, 8'h06);
        rd(ADDR_EVENT, 8'h00);
        wr(ADDR_MODE_BASE + 8'h01, 8'h20);
        cap = 16'($random(seed));
        i_count = cap;
        want = 3'h2;
        repeat (6) @(negedge i_clk);
        rd(ADDR_CMP_BASE + 8'h02, cap[7:0]);
        rd(ADDR_CMP_BASE + 8'h03, cap[15:8]);
        rd(ADDR_PIN_LEVEL, 8'h02);
        i_count = cap + 16'h0001;
        want = 3'h0;
        repeat (6) @(negedge i_clk);
        rd(ADDR_CMP_BASE + 8'h02, cap[7:0]);
        wr(ADDR_MODE_BASE + 8'h02, 8'h4c);
        wr(ADDR_CMP_BASE + 8'h04, 8'h10);
        wr(ADDR_CMP_BASE + 8'h05, 8'h00);
        step(16'h0010);
        check("hso pin", {14'h0, o_pin_oe_n[2], o_pin[2]}, 16'h0001);
        rd(ADDR_EVENT, 8'h06);
        wr(ADDR_CMP_BASE + 8'h04, 8'h10);
        step(16'h0010);
        check("hso pin", {15'h0, o_pin[2]}, 16'h0001);
        wr(ADDR_EVENT, 8'h00);
        wr(ADDR_PWM_CFG, 8'h20);
        wr(ADDR_MODE_BASE, 8'h4a);
        wr(ADDR_CMP_BASE, 8'hc0);
        wr(ADDR_CMP_BASE + 8'h01, 8'h40);
        step(16'h00c0);
        check("pwm pin", {15'h0, o_pin[0]}, 16'h0001);
        rd(ADDR_EVENT, 8'h01);
        step(16'h0100);
        check("pwm pin", {15'h0, o_pin[0]}, 16'h0000);
        rd(ADDR_CMP_BASE, 8'h40);
        rd(ADDR_PWM_CFG, 8'h60);
        check("ovf irq", {15'h0, o_overflow_irq}, 16'h0001);
        step(16'h0140);
        check("pwm pin", {14'h0, o_pin_oe_n[0], o_pin[0]}, 16'h0001);
        wr(ADDR_CMP_BASE, 8'h40);
        step(16'h0240);
        check("pwm pin", {15'h0, o_pin[0]}, 16'h0000);
        wr(ADDR_PWM_CFG, 8'h9d);
        @(negedge i_clk);
        check("ovf irq", {15'h0, o_overflow_irq}, 16'h0000);
        rd(ADDR_PWM_CFG, 8'h81);
        wr(ADDR_CMP_BASE, 8'h55);
        rd(ADDR_CMP_BASE, 8'h55);
        wr(ADDR_PWM_CFG, 8'h01);
        rd(ADDR_CMP_BASE, 8'h40);
        wr(ADDR_PWM_CFG, 8'h81);
        wr(ADDR_CMP_BASE, 8'h80);
        wr(ADDR_CMP_BASE + 8'h01, 8'h01);
        wr(ADDR_PWM_CFG, 8'h01);
        step(16'h0200);
        rd(ADDR_CMP_BASE, 8'h80);
        rd(ADDR_CMP_BASE + 8'h01, 8'h41);
        step(16'h0380);
        check("pwm9 pin", {15'h0, o_pin[0]}, 16'h0001);
        wr(ADDR_MODE_BASE, 8'h82);
        wr(ADDR_CMP_BASE, 8'h00);
        wr(ADDR_CMP_BASE + 8'h01, 8'h80);
        step(16'h8000);
        step(16'h0200);
        check("pwm16 pin", {15'h0, o_pin[0]}, 16'h0001);
        step(16'h0000);
        check("pwm16 pin", {15'h0, o_pin[0]}, 16'h0000);
        wr(ADDR_MODE_BASE + 8'h02, 8'h4e);
        wr(ADDR_CMP_BASE + 8'h04, 8'h10);
        wr(ADDR_CMP_BASE + 8'h05, 8'h05);
        step(16'h0010);
        check("freq pin", {15'h0, o_pin[2]}, 16'h0000);
        rd(ADDR_EVENT, 8'h01);
        rd(ADDR_CMP_BASE + 8'h04, 8'h15);
        step(16'h0014);
        check("freq pin", {15'h0, o_pin[2]}, 16'h0000);
        step(16'h0515);
        check("freq pin", {15'h0, o_pin[2]}, 16'h0001);
        rd(ADDR_EVENT, 8'h05);
        wr(ADDR_CMP_BASE + 8'h04, 8'h20);
        wr(ADDR_CMP_BASE + 8'h05, 8'h00);
        step(16'h0020);
        rd(ADDR_CMP_BASE + 8'h04, 8'h20);
        repeat (2) @(negedge i_clk);
        check("pending reads", 16'(exp_q.size()), 16'h0000);
        stop_test();
    end
endmodule
